/* core/trrs_pkg.sv */
// package for the temperature result and status register block
package trrs_pkg;
  // register pointer values
  localparam logic [7:0] ADDR_TEMP_UPPER = 8'h00;
  localparam logic [7:0] ADDR_TEMP_LOWER = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  // reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic RDY_N_RESET = 1'b1;
  // status byte field positions
  localparam int STAT_LOW_BIT = 4;
  localparam int STAT_HIGH_BIT = 5;
  localparam int STAT_CRIT_BIT = 6;
  localparam int STAT_RDY_BIT = 7;
  localparam logic [3:0] STAT_UNUSED = 4'h0;
  // result flag positions in 13-bit mode
  localparam int FLAG_LOW_BIT = 0;
  localparam int FLAG_HIGH_BIT = 1;
  localparam int FLAG_CRIT_BIT = 2;
  localparam int FLAG_WIDTH = 3;
  // hysteresis is whole degrees, result lsb is 1/128 degree
  localparam int HYST_SHIFT = 7;
  // operation mode encodings
  typedef enum logic [1:0] {
    TRRS_MODE_CONT = 2'h0,
    TRRS_MODE_ONE_SHOT = 2'h1,
    TRRS_MODE_ONE_SPS = 2'h2,
    TRRS_MODE_SHUTDOWN = 2'h3
  } trrs_mode_t;
  // limit set that the comparisons use
  typedef struct packed {
    logic [15:0] low_limit;
    logic [15:0] high_limit;
    logic [15:0] critical_limit;
    logic [7:0] hysteresis_value;
  } trrs_limits_t;
  // host byte access request
  typedef struct packed {
    logic ptr_load;
    logic [7:0] ptr_value;
    logic rd_req;
  } trrs_host_req_t;
endpackage

/* core/trrs_regs.sv */
// temperature result, status byte and auto-incrementing read pointer
// Functional notes
// - upper and lower bytes correct, one or two-byte reads
// - pointer increments after each byte read
// - twos complement result, sign bit 15, resets zero
// - 13-bit mode: bit 0 flags below low
// - 13-bit mode: bit 1 flags above high
// - 13-bit mode: bit 2 flags above critical
// - 16-bit mode: bits 2:0 hold result lsbs
// - status bit 4 low alarm, sticky with hysteresis
// - status bit 5 high alarm, sticky with hysteresis
// - status bit 6 critical alarm, sticky with hysteresis
// - ready-low drops on new result, rises on an upper or lower result byte read
// - mode write in one-shot/1 sps sets ready
// - mode field selects continuous, one-shot, 1 sps, shutdown
`timescale 1ns/1ps
module trrs_regs (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // conversion result from the converter
  input wire logic conv_valid_i,
  input wire logic [15:0] conv_raw_i,
  // configuration and limits
  input wire logic resolution_16_i,
  input wire trrs_pkg::trrs_limits_t limits_i,
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_wr_data_i,
  // host byte access
  input wire trrs_pkg::trrs_host_req_t host_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic [7:0] ptr_o,
  output logic [7:0] status_o
);
  logic [7:0] ptr;
  logic [15:0] temp_val;
  logic st_low;
  logic st_high;
  logic st_crit;
  logic rdy_n;
  logic [7:0] lower_shadow;
  logic shadow_ok;
  logic [7:0] next_rd_data;
  logic [7:0] next_ptr;

  // request decode
  wire act = ce_i;
  wire rd = act && host_req_i.rd_req;
  wire ld = act && host_req_i.ptr_load;
  wire conv = act && conv_valid_i;
  wire rd_upper = rd && (ptr == trrs_pkg::ADDR_TEMP_UPPER);
  wire rd_lower = rd && (ptr == trrs_pkg::ADDR_TEMP_LOWER);
  wire rd_status = rd && (ptr == trrs_pkg::ADDR_STATUS);
  wire rd_temp = rd_upper || rd_lower;

  // comparison value: 13-bit mode ignores the three lsbs
  wire [15:0] cmp_raw = resolution_16_i ? conv_raw_i : {conv_raw_i[15:3], 3'h0};
  wire signed [17:0] t_s = {{2{cmp_raw[15]}}, cmp_raw};
  wire signed [17:0] lo_s = {{2{limits_i.low_limit[15]}}, limits_i.low_limit};
  wire signed [17:0] hi_s = {{2{limits_i.high_limit[15]}}, limits_i.high_limit};
  wire signed [17:0] cr_s = {{2{limits_i.critical_limit[15]}}, limits_i.critical_limit};
  wire signed [17:0] hy_s = {3'h0, limits_i.hysteresis_value, 7'h00};

  // limit events and hysteresis returns
  wire below_low = t_s < lo_s;
  wire above_high = t_s > hi_s;
  wire above_crit = t_s > cr_s;
  wire low_back = t_s > (lo_s + hy_s);
  wire high_back = t_s < (hi_s - hy_s);
  wire crit_back = t_s < (cr_s - hy_s);

  // new result word: flags or extended lsbs in bits 2:0
  wire [2:0] flag_bits = {above_crit, above_high, below_low};
  wire [15:0] next_temp = resolution_16_i ? conv_raw_i
                                          : {conv_raw_i[15:3], flag_bits};

  // mode write only releases ready in one-shot and 1 sps
  wire mode_rdy = act && mode_wr_i &&
                  ((mode_wr_data_i == trrs_pkg::TRRS_MODE_ONE_SHOT) ||
                   (mode_wr_data_i == trrs_pkg::TRRS_MODE_ONE_SPS));

  // status byte, low nibble unused
  wire [7:0] status_byte = {rdy_n, st_crit, st_high, st_low, trrs_pkg::STAT_UNUSED};

  // lower byte of a two-byte read comes from the snapshot taken with the upper
  wire [7:0] lower_src = shadow_ok ? lower_shadow : temp_val[7:0];

  // read data selection, unmapped pointers read zero
  always_comb begin
    case (ptr)
      trrs_pkg::ADDR_TEMP_UPPER: next_rd_data = temp_val[15:8];
      trrs_pkg::ADDR_TEMP_LOWER: next_rd_data = lower_src;
      trrs_pkg::ADDR_STATUS: next_rd_data = status_byte;
      default: next_rd_data = 8'h00;
    endcase
  end

  // pointer: a load wins, otherwise advance after each byte
  always_comb begin
    next_ptr = ptr;
    if (ld) begin
      next_ptr = host_req_i.ptr_value;
    end else if (rd) begin
      next_ptr = ptr + 8'h01;
    end
  end

  // pointer and read data register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ptr <= trrs_pkg::PTR_RESET;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      ptr <= next_ptr;
      rd_valid_o <= rd;
      if (rd) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  // snapshot of the lower byte, valid from an upper read until the next byte read or pointer load
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lower_shadow <= 8'h00;
      shadow_ok <= 1'b0;
    end else if (rd_upper) begin
      lower_shadow <= temp_val[7:0];
      shadow_ok <= 1'b1;
    end else if (rd || ld) begin
      shadow_ok <= 1'b0;
    end
  end

  // result and flags load together at end of conversion
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      temp_val <= trrs_pkg::TEMP_RESET;
    end else if (conv) begin
      temp_val <= next_temp;
    end
  end

  // sticky alarms: a new event wins over a read clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_low <= 1'b0;
      st_high <= 1'b0;
      st_crit <= 1'b0;
    end else begin
      if (conv && below_low) begin
        st_low <= 1'b1;
      end else if (rd_status || (conv && low_back)) begin
        st_low <= 1'b0;
      end
      if (conv && above_high) begin
        st_high <= 1'b1;
      end else if (rd_status || (conv && high_back)) begin
        st_high <= 1'b0;
      end
      if (conv && above_crit) begin
        st_crit <= 1'b1;
      end else if (rd_status || (conv && crit_back)) begin
        st_crit <= 1'b0;
      end
    end
  end

  // ready-low: a new result wins over a release
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdy_n <= trrs_pkg::RDY_N_RESET;
    end else if (conv) begin
      rdy_n <= 1'b0;
    end else if (rd_temp || mode_rdy) begin
      rdy_n <= 1'b1;
    end
  end

  // state visible to the surrounding device
  assign ptr_o = ptr;
  assign status_o = status_byte;

  // reference levels for the checks below, worked out apart from the datapath
  wire [15:0] ref_raw = resolution_16_i ? conv_raw_i : {conv_raw_i[15:3], 3'h0};
  wire signed [31:0] ref_t = {{16{ref_raw[15]}}, ref_raw};
  wire signed [31:0] ref_lo = {{16{limits_i.low_limit[15]}}, limits_i.low_limit};
  wire signed [31:0] ref_hi = {{16{limits_i.high_limit[15]}}, limits_i.high_limit};
  wire signed [31:0] ref_cr = {{16{limits_i.critical_limit[15]}}, limits_i.critical_limit};
  wire signed [31:0] ref_hy = {17'h0, limits_i.hysteresis_value, 7'h00};
  wire ref_below = ref_t < ref_lo;
  wire ref_above_high = ref_t > ref_hi;
  wire ref_above_crit = ref_t > ref_cr;
  wire ref_low_back = ref_t > ref_lo + ref_hy;
  wire ref_high_back = ref_t < ref_hi - ref_hy;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  ptr_auto_inc_a: assert property (
    (ce_i && host_req_i.rd_req && !host_req_i.ptr_load) |=> (ptr_o == $past(ptr_o) + 8'h01))
    else $error("pointer did not advance after byte read");

  two_byte_read_a: assert property (
    (ce_i && host_req_i.rd_req && !host_req_i.ptr_load && ptr_o == trrs_pkg::ADDR_TEMP_UPPER)
    ##1 (ce_i && host_req_i.rd_req && !host_req_i.ptr_load)
    |=> (rd_valid_o && rd_data_o == $past(temp_val[7:0], 2)))
    else $error("two-byte read returned wrong lower byte");

  flags_13bit_a: assert property (
    (ce_i && conv_valid_i && !resolution_16_i)
    |=> (temp_val[0] == $past(ref_below) && temp_val[15:3] == $past(conv_raw_i[15:3])))
    else $error("13-bit result flags wrong");

  high_flag_13bit_a: assert property (
    (ce_i && conv_valid_i && !resolution_16_i) |=> (temp_val[1] == $past(ref_above_high)))
    else $error("13-bit high flag wrong");

  crit_flag_13bit_a: assert property (
    (ce_i && conv_valid_i && !resolution_16_i) |=> (temp_val[2] == $past(ref_above_crit)))
    else $error("13-bit critical flag wrong");

  upper_byte_read_a: assert property (
    (ce_i && host_req_i.rd_req && ptr_o == trrs_pkg::ADDR_TEMP_UPPER)
    |=> (rd_valid_o && rd_data_o == $past(temp_val[15:8])))
    else $error("upper byte read back wrong");

  result_reset_a: assert property (
    $past(sys_rst_i) |-> (temp_val == trrs_pkg::TEMP_RESET && ptr_o == trrs_pkg::PTR_RESET &&
                          status_o == {trrs_pkg::RDY_N_RESET, 7'h00}))
    else $error("state after reset wrong");

  result_hold_a: assert property (
    !(ce_i && conv_valid_i) |=> $stable(temp_val))
    else $error("result changed without a conversion");

  result_16bit_a: assert property (
    (ce_i && conv_valid_i && resolution_16_i) |=> (temp_val == $past(conv_raw_i)))
    else $error("16-bit result not stored whole");

  low_alarm_set_a: assert property (
    (ce_i && conv_valid_i && below_low) |=> st_low ##1 (st_low || $past(rd_status || conv)))
    else $error("low alarm not set or lost");

  low_hyst_clr_a: assert property (
    (ce_i && conv_valid_i && ref_low_back) |=> !st_low)
    else $error("low alarm not cleared by hysteresis");

  high_alarm_set_a: assert property (
    (ce_i && conv_valid_i && ref_above_high) |=> st_high)
    else $error("high alarm not set");

  high_hyst_clr_a: assert property (
    (ce_i && conv_valid_i && ref_high_back) |=> !st_high)
    else $error("high alarm not cleared by hysteresis");

  crit_alarm_set_a: assert property (
    (ce_i && conv_valid_i && ref_above_crit) |=> st_crit)
    else $error("critical alarm not set");

  alarm_read_clr_a: assert property (
    (rd_status && !conv) |=> (!st_low && !st_high && !st_crit))
    else $error("status read did not clear alarms");

  crit_hyst_clr_a: assert property (
    (conv && crit_back && !above_crit) |=> !st_crit)
    else $error("critical alarm not cleared by hysteresis");

  rdy_drop_a: assert property (
    (ce_i && conv_valid_i) |=> !status_o[trrs_pkg::STAT_RDY_BIT])
    else $error("ready-low did not drop on new result");

  rdy_release_a: assert property (
    ((rd_temp || mode_rdy) && !conv) |=> status_o[trrs_pkg::STAT_RDY_BIT])
    else $error("ready-low not released");

  mode_keep_rdy_a: assert property (
    (ce_i && mode_wr_i && !conv_valid_i && !host_req_i.rd_req &&
     (mode_wr_data_i == trrs_pkg::TRRS_MODE_CONT ||
      mode_wr_data_i == trrs_pkg::TRRS_MODE_SHUTDOWN))
    |=> $stable(rdy_n))
    else $error("ready-low moved on a continuous or shutdown write");

  freeze_all_a: assert property (
    !ce_i |=> ($stable(ptr_o) && $stable(status_o) &&
               $stable(rd_data_o) && $stable(rd_valid_o)))
    else $error("state moved while disabled");

  status_read_a: assert property (
    rd_status |=> (rd_data_o[3:0] == 4'h0 && rd_data_o[7] == $past(rdy_n)))
    else $error("status byte read back wrong");

  cov_two_byte_c: cover property (rd_upper ##1 rd_lower);
  cov_event_clear_c: cover property ((conv && below_low) ##[1:20] rd_status);
  cov_mode_rdy_c: cover property (conv ##[1:20] mode_rdy);
  cov_16bit_c: cover property (conv && resolution_16_i);
  cov_crit_clear_c: cover property ((conv && above_crit) ##[1:40] (conv && crit_back));
endmodule

/* verification/trrs_host_model.sv */
// host side model issuing pointer loads and byte reads
`timescale 1ns/1ps
module trrs_host_model (
  // clock
  input wire logic clk_sys_i,
  // answer from the block
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  // request to the block
  output trrs_pkg::trrs_host_req_t host_req_o
);
  initial host_req_o = '0;
  // one-cycle pointer load, value scrambled once released
  task automatic load(input logic [7:0] p);
    @(negedge clk_sys_i);
    host_req_o.ptr_load = 1'b1;
    host_req_o.ptr_value = p;
    @(negedge clk_sys_i);
    host_req_o.ptr_load = 1'b0;
    host_req_o.ptr_value = ~p;
  endtask
  // n back-to-back byte reads, with n of 2 the first byte ends in the upper half
  task automatic read(input int n, output logic [15:0] d, output logic v);
    d = '0;
    v = 1'b1;
    @(negedge clk_sys_i);
    host_req_o.rd_req = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys_i);
      d = {d[7:0], rd_data_i};
      v &= rd_valid_i;
      if (i == n - 1) host_req_o.rd_req = 1'b0;
    end
  endtask
endmodule

/* verification/temp_result_status_regs_test.sv */
// self-checking bench for the result and status registers
`timescale 1ns/1ps
module temp_result_status_regs_test;
  // alarm limits in result lsbs, hysteresis in whole degrees; a second set loads mid-run
  int lim_low = 32'h0000_0500;
  int lim_high = 32'h0000_2000;
  int lim_crit = 32'h0000_4980;
  int lim_hys = 32'h0000_0005;
  logic clk_sys_i, sys_rst_i, ce, cv, res16, mw, rv, v;
  logic [15:0] raw, d, e;
  logic [1:0] mwd;
  logic [7:0] rdd, ptr, status, lf;
  logic [2:0] alm;
  trrs_pkg::trrs_limits_t lim;
  trrs_pkg::trrs_host_req_t req;
  logic [15:0] corner [4] = '{16'h0500, 16'h04F8, 16'h2008, 16'h4988};
  int fails, checks_done;
  trrs_regs trrs_regs_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .conv_valid_i(cv), .conv_raw_i(raw), .resolution_16_i(res16), .limits_i(lim),
    .mode_wr_i(mw), .mode_wr_data_i(mwd), .host_req_i(req), .rd_data_o(rdd),
    .rd_valid_o(rv), .ptr_o(ptr), .status_o(status));
  trrs_host_model trrs_host_model_inst (.clk_sys_i(clk_sys_i), .rd_data_i(rdd),
    .rd_valid_i(rv), .host_req_o(req));
  // 5 ns clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // comparison and verdict
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
    checks_done++;
    if (s !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // expectation helpers
  function automatic int tval(input logic [15:0] r, input logic m);
    return m ? $signed(r) : $signed(r & 16'hFFF8);
  endfunction
  function automatic logic [15:0] exp_temp(input logic [15:0] r, input logic m);
    int t;
    t = tval(r, m);
    return m ? r : {r[15:3], t > lim_crit, t > lim_high, t < lim_low};
  endfunction
  function automatic logic [2:0] exp_alarm(input logic [2:0] a, input int t);
    exp_alarm[0] = t < lim_low ? 1'b1 : (t > lim_low + lim_hys * 128 ? 1'b0 : a[0]);
    exp_alarm[1] = t > lim_high ? 1'b1 : (t < lim_high - lim_hys * 128 ? 1'b0 : a[1]);
    exp_alarm[2] = t > lim_crit ? 1'b1 : (t < lim_crit - lim_hys * 128 ? 1'b0 : a[2]);
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one conversion pulse, expected alarms follow it
  task automatic conv(input logic [15:0] r);
    @(negedge clk_sys_i);
    cv = 1'b1;
    raw = r;
    @(negedge clk_sys_i);
    cv = 1'b0;
    alm = exp_alarm(alm, tval(r, res16));
    check("ready_n after conversion", status[7], 1'b0);
    check("alarms", status[6:4], alm);
  endtask
  // timeout guard
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    {ce, cv, res16, mw, mwd, raw, alm, fails, checks_done} = '0;
    ce = 1'b1;
    lf = 8'h52;
    lim = '{lim_low[15:0], lim_high[15:0], lim_crit[15:0], lim_hys[7:0]};
    repeat (3) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    check("status at reset", status, 8'h80);
    trrs_host_model_inst.read(2, d, v);
    check("result at reset", d, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      // second limit set: negative low limit, narrower hysteresis
      if (i == 20) begin
        lim_low = 32'hFFFF_F000;
        lim_high = 32'h0000_0C80;
        lim_crit = 32'h0000_1900;
        lim_hys = 32'h0000_0002;
        lim = '{lim_low[15:0], lim_high[15:0], lim_crit[15:0], lim_hys[7:0]};
      end
      lf = nxt(lf);
      res16 = lf[0];
      e[15:8] = nxt(lf);
      lf = nxt(e[15:8]);
      conv(i < 4 ? corner[i] : {e[15:8], lf});
      if (i % 2 == 1) begin
        trrs_host_model_inst.load(8'h00);
        trrs_host_model_inst.read(2, d, v);
      end else begin
        trrs_host_model_inst.load(8'h01);
        trrs_host_model_inst.read(1, e, v);
        trrs_host_model_inst.load(8'h00);
        trrs_host_model_inst.read(1, d, v);
        d = {d[7:0], e[7:0]};
      end
      check("result", d, exp_temp(raw, res16));
      check("read valid", v, 1'b1);
      check("pointer", ptr, i % 2 == 1 ? 8'h02 : 8'h01);
      check("ready_n after read", status[7], 1'b1);
      if (i % 3 == 0) begin
        trrs_host_model_inst.load(8'h02);
        trrs_host_model_inst.read(1, d, v);
        check("status byte", d[7:0], {1'b1, alm, 4'h0});
        alm = '0;
        check("alarms after read", status[6:4], 3'h0);
      end
    end
    // mode writes release ready_n only in one-shot and 1 sps
    for (int m = 0; m < 4; m++) begin
      conv(16'h0190);
      @(negedge clk_sys_i);
      mw = 1'b1;
      mwd = m[1:0];
      @(negedge clk_sys_i);
      mw = 1'b0;
      check("ready_n after mode write", status[7], m == 1 || m == 2);
    end
    // unmapped place reads zero and still advances
    trrs_host_model_inst.load(8'h05);
    trrs_host_model_inst.read(1, d, v);
    check("unmapped byte", d[7:0], 8'h00);
    check("pointer after unmapped", ptr, 8'h06);
    // requests ignored while disabled
    @(negedge clk_sys_i);
    ce = 1'b0;
    trrs_host_model_inst.load(8'h07);
    check("pointer frozen", ptr, 8'h06);
    trrs_host_model_inst.read(1, d, v);
    check("read refused", v, 1'b0);
    check("pointer still frozen", ptr, 8'h06);
    ce = 1'b1;
    complete_run();
  end
endmodule
